// *** dv/serial_flash_io_mode_control_properties.sv ***
// Concurrent checks on the ports of the flash front end.
`timescale 1ns/10ps
`default_nettype none
module serial_flash_io_mode_control_properties
  import flash_io_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic rst_b, // Reset.
  input wire logic cs_b, // Select.
  input wire logic [3:0] io_in, // Line levels.
  input wire logic [3:0] io_oe, // Drive enables.
  input wire logic quad_lines_enable, // Quad enable.
  input wire logic [1:0] register_protect_bits, // Protect setting.
  input wire logic status_write_block, // Writes refused.
  input wire logic four_wire_instruction_mode, // Four-wire mode.
  input wire logic reset_busy, // Reset running.
  input wire logic rx_valid, // Byte pulse.
  input wire logic tx_valid, // Byte offered.
  input wire logic tx_ready // Byte taken.
);
  logic [BUSY_CNT_W-1:0] busy_cnt_r; // Busy cycles so far.

  // The recovery is far too long to unroll, so it is counted here.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_r <= BUSY_IDLE;
    end else begin
      busy_cnt_r <= reset_busy ? busy_cnt_r + 12'h001 : BUSY_IDLE;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Protect pin held low under pin protection, or the pin given to data.
  sequence pin_lock_s;
    (!quad_lines_enable && register_protect_bits == PROTECT_BY_PIN && !io_in[LINE_PROTECT])[*6];
  endsequence
  sequence pin_free_s;
    (quad_lines_enable && register_protect_bits == PROTECT_BY_PIN)[*6];
  endsequence

  idle_float_a: assert property (cs_b |-> io_oe == 4'h0)
    else $error("Lines driven while deselected.");
  quad_lines_a: assert property (!quad_lines_enable |-> io_oe[3:2] == 2'h0)
    else $error("Upper lines driven without quad enable.");
  mode_gate_a: assert property ($rose(four_wire_instruction_mode) |-> quad_lines_enable)
    else $error("Four-wire mode without quad enable.");
  mode_reset_a: assert property ($rose(reset_busy) |-> ##[0:6] !four_wire_instruction_mode)
    else $error("Reset left four-wire mode on.");
  pin_lock_a: assert property (pin_lock_s |-> status_write_block)
    else $error("Protect pin low but writes allowed.");
  pin_free_a: assert property (pin_free_s |-> !status_write_block)
    else $error("Data line still acts as protect.");
  busy_quiet_a: assert property (reset_busy [*6] |-> !rx_valid)
    else $error("Byte taken during reset.");
  busy_time_a: assert property ($fell(reset_busy) |-> busy_cnt_r >= SOFT_RESET_CYCLES - 2)
    else $error("Reset recovery too short.");
  tx_take_a: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("Read byte not taken.");
endmodule : serial_flash_io_mode_control_properties

bind serial_flash_io_mode_control serial_flash_io_mode_control_properties i_props (
  .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .io_in(io_in), .io_oe(io_oe),
  .quad_lines_enable(quad_lines_enable), .register_protect_bits(register_protect_bits),
  .status_write_block(status_write_block), .reset_busy(reset_busy), .rx_valid(rx_valid),
  .four_wire_instruction_mode(four_wire_instruction_mode), .tx_valid(tx_valid),
  .tx_ready(tx_ready));
`default_nettype wire

// *** dv/serial_flash_io_mode_control_tb.sv ***
// Self-checking bench for the flash pin-function front end.
`timescale 1ns/10ps
`default_nettype none
module serial_flash_io_mode_control_tb;
  import flash_io_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic qe = 1'b0;
  logic [1:0] rpb = 2'h1;
  logic [7:0] tx_byte = 8'h00;
  logic tx_valid = 1'b0;
  logic prst = 1'b0;
  wire sclk, cs_b, swb, fwm, busy, rx_instr, rx_valid, tx_ready;
  wire [3:0] io_in, io_out, io_oe;
  wire [7:0] rx_byte;
  int n_fail = 0;
  int checks = 0;
  int rx_cnt = 0;
  int base = 0;
  logic [7:0] b;
  logic [3:0] oe_run, oe_gap;
  logic [7:0] ops [5] = '{8'h3b, 8'hbb, 8'h6b, 8'heb, 8'he7};

  serial_flash_io_mode_control i_dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_lines_enable(qe),
    .pause_pin_is_reset(prst), .register_protect_bits(rpb), .status_write_block(swb),
    .four_wire_instruction_mode(fwm), .reset_busy(busy), .rx_byte(rx_byte),
    .rx_is_instruction(rx_instr), .rx_valid(rx_valid), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  spi_host_model i_host (.sclk(sclk), .cs_b(cs_b), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));

  // Clock, and a count of byte pulses so refused frames show.
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // The byte is held until a rising edge sees tx_ready high.
  task automatic offer(input logic [7:0] v);
    @(negedge clk);
    tx_byte = v;
    tx_valid = 1'b1;
    for (int k = 0; k < 200 && tx_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask : offer

  task automatic run(input logic [7:0] op, input bit four);
    base = rx_cnt;
    i_host.frame(1'b1);
    i_host.send_byte(op, four);
    i_host.frame(1'b0);
    repeat (40) @(negedge clk);
  endtask : run

  task automatic read(input logic [7:0] op, input logic [7:0] v, input int n, input int gap);
    offer(v);
    i_host.frame(1'b1);
    i_host.send_byte(op, 1'b0);
    i_host.read_byte(n, gap, b, oe_run, oe_gap);
    i_host.frame(1'b0);
    check(b, v);
    check({4'h0, oe_run}, n == 1 ? 8'h02 : n == 2 ? 8'h03 : 8'h0f);
  endtask : read

  task automatic cfg(input logic q, input logic [1:0] r, input logic p);
    @(negedge clk);
    qe = q;
    rpb = r;
    i_host.protect_b = p;
    repeat (8) @(negedge clk);
  endtask : cfg

  // Line 3 held low with the reset choice made: a reset only with quad enable clear.
  task automatic pin3(input logic q, input logic [7:0] exp);
    cfg(q, 2'h1, 1'b1);
    prst = 1'b1;
    i_host.pause_b = 1'b0;
    repeat (8) @(negedge clk);
    check({6'h0, busy, fwm}, exp);
    i_host.pause_b = 1'b1;
    prst = 1'b0;
    for (int k = 0; k < 4000 && busy !== 1'b0; k++) @(negedge clk);
    check({7'h0, busy}, 8'h00);
  endtask : pin3

  // Watchdog well beyond the expected run of about 75 us.
  initial begin
    #200us;
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check({3'h0, fwm, io_oe}, 8'h00);
    run(8'h9f, 1'b0);
    check(8'(rx_cnt - base), 8'h00);
    i_host.idle_hi = 1'b1;
    run(8'h9f, 1'b0);
    i_host.idle_hi = 1'b0;
    check({rx_byte[6:0], rx_instr}, 8'h3f);
    read(8'h03, 8'ha5, 1, 4);
    check({4'h0, oe_gap}, 8'h00);
    cfg(1'b1, 2'h1, 1'b1);
    foreach (ops[i]) read(ops[i], ops[i] ^ 8'h5a, i < 2 ? 2 : 4, -1);
    cfg(1'b0, 2'h1, 1'b1);
    run(OP_QUAD_OUT_READ, 1'b0);
    check(8'(rx_cnt - base), 8'h00);
    run(OP_ENTER_FOUR_WIRE, 1'b0);
    check({7'h0, fwm}, 8'h00);
    cfg(1'b1, 2'h1, 1'b1);
    run(OP_ENTER_FOUR_WIRE, 1'b0);
    check({7'h0, fwm}, 8'h01);
    run(8'h9f, 1'b1);
    check(rx_byte, 8'h9f);
    run(OP_EXIT_FOUR_WIRE, 1'b1);
    check({7'h0, fwm}, 8'h00);
    run(OP_RESET_ENABLE, 1'b0);
    run(8'h9f, 1'b0);
    run(OP_RESET, 1'b0);
    check({6'h0, busy, fwm}, 8'h00);
    run(OP_ENTER_FOUR_WIRE, 1'b0);
    run(OP_RESET_ENABLE, 1'b1);
    run(OP_RESET, 1'b1);
    check({6'h0, busy, fwm}, 8'h02);
    run(8'h9f, 1'b0);
    check(8'(rx_cnt - base), 8'h00);
    for (int k = 0; k < 4000 && busy !== 1'b0; k++) @(negedge clk);
    run(8'h9f, 1'b0);
    check(8'(rx_cnt - base), 8'h01);
    cfg(1'b0, 2'h1, 1'b0);
    check({7'h0, swb}, 8'h01);
    cfg(1'b0, 2'h1, 1'b1);
    check({7'h0, swb}, 8'h00);
    cfg(1'b1, 2'h1, 1'b0);
    check({7'h0, swb}, 8'h00);
    cfg(1'b1, 2'h2, 1'b0);
    check({7'h0, swb}, 8'h01);
    pin3(1'b1, 8'h00);
    pin3(1'b0, 8'h02);
    stop_test();
  end
endmodule : serial_flash_io_mode_control_tb
`default_nettype wire

// *** dv/spi_host_model.sv ***
// Behavioural host that clocks frames into the flash front end.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output logic sclk, // Still between frames.
  output logic cs_b, // Select, active low.
  output logic [3:0] io_in, // Resolved lines.
  input wire logic [3:0] io_out, // Device levels.
  input wire logic [3:0] io_oe // Device enables.
);
  logic [3:0] d_r = 4'h0; // Last host value.
  logic [3:0] hoe_r = 4'h0; // Host enables.
  logic protect_b = 1'b1; // Protect pin.
  logic pause_b = 1'b1; // Pause pin.
  logic idle_hi = 1'b0; // Clock rests high.

  // A released line 0 or 1 reads the inverse of its last value, so stale bits never pass; lines 2 and 3 read the protect and pause pins.
  assign io_in = (io_oe & io_out) | (~io_oe & hoe_r & d_r) |
    (~io_oe & ~hoe_r & {pause_b, protect_b, ~d_r[1:0]});

  // Select starts low, as from a host that has not yet set up its pins.
  initial begin
    sclk = 1'b0;
    cs_b = 1'b0;
  end

  // Select and deselect only with the clock at rest.
  task automatic frame(input bit on);
    sclk = idle_hi;
    hoe_r = 4'h0;
    // The odd delay keeps the link edges off the system clock edges.
    #35;
    cs_b = !on;
    #32;
  endtask : frame

  // Host lines change at the falling edge; the device is read at the rising one.
  task automatic beat(input logic [3:0] d, input logic [3:0] hoe, output logic [3:0] q);
    sclk = 1'b0;
    if (hoe != 4'h0) d_r = d;
    hoe_r = hoe;
    #32;
    sclk = 1'b1;
    q = io_in;
    #32;
  endtask : beat

  task automatic send_byte(input logic [7:0] v, input bit four);
    logic [3:0] q;
    if (four) begin
      beat(v[7:4], 4'hf, q);
      beat(v[3:0], 4'hf, q);
    end else begin
      for (int i = 7; i >= 0; i--) beat({3'h0, v[i]}, 4'h1, q);
    end
  endtask : send_byte

  // Pause goes low with the clock high, so the next falling edge applies it.
  task automatic read_byte(input int lanes, input int gap, output logic [7:0] v,
                           output logic [3:0] oe_run, output logic [3:0] oe_gap);
    logic [3:0] q;
    v = 8'h00;
    oe_gap = 4'hf;
    for (int i = 0; i < 8 / lanes; i++) begin
      if (i == gap) begin
        pause_b = 1'b0;
        beat(4'h0, 4'h0, q);
        beat(4'h0, 4'h0, q);
        oe_gap = io_oe;
        pause_b = 1'b1;
      end
      beat(4'h0, 4'h0, q);
      oe_run = io_oe;
      v = (lanes == 1) ? {v[6:0], q[1]} : (lanes == 2) ? {v[5:0], q[1:0]} : {v[3:0], q};
    end
  endtask : read_byte
endmodule : spi_host_model
`default_nettype wire

// *** rtl/bit_sync.sv ***
// Two-flop synchroniser for one level signal.
`timescale 1ns/10ps
`default_nettype none
module bit_sync (
  input wire logic clk, // Clock of the receiving domain.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic d, // Level from another domain or a pin.
  output logic q // Level safe to use in the receiving domain.
);

  logic meta_r;
  logic sync_r;

  // The first flop is read only by the second one.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule : bit_sync
`default_nettype wire

// *** rtl/flash_io_pkg.sv ***
// Constants shared by the serial flash pin-function and bus-mode front end.
package flash_io_pkg;

  // Instruction codes that the front end acts on by itself.
  localparam logic [7:0] OP_ENTER_FOUR_WIRE = 8'h38;
  localparam logic [7:0] OP_EXIT_FOUR_WIRE = 8'hff;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;

  // Instructions that widen the lines after the instruction byte.
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] OP_QUAD_WORD_READ = 8'he7;

  // Number of data lines in use, also the bits moved per clock.
  localparam logic [3:0] LANES_1 = 4'h1;
  localparam logic [3:0] LANES_2 = 4'h2;
  localparam logic [3:0] LANES_4 = 4'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BITS_NONE = 4'h0;

  // Pin positions on the four data lines.
  localparam int LINE_IN = 0;
  localparam int LINE_OUT = 1;
  localparam int LINE_PROTECT = 2;
  localparam int LINE_PAUSE = 3;

  // Register protect settings that lock status register writes.
  localparam logic [1:0] PROTECT_BY_PIN = 2'h1;
  localparam int PROTECT_LOCK_BIT = 1;

  // Software reset recovery time and its length in system clocks.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SOFT_RESET_TIME_NS = 28000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int BUSY_CNT_W = 12;
  localparam logic [BUSY_CNT_W-1:0] BUSY_LOAD = BUSY_CNT_W'(SOFT_RESET_CYCLES);
  localparam logic [BUSY_CNT_W-1:0] BUSY_IDLE = 12'h000;

endpackage : flash_io_pkg

// *** rtl/serial_flash_io_mode_control.sv ***
// Pin-function, line-width, pause and instruction-mode front end of a serial flash.
`timescale 1ns/10ps
`default_nettype none
module serial_flash_io_mode_control
  import flash_io_pkg::*;
(
  input wire logic clk, // System clock, 125 MHz.
  input wire logic rst_b, // Power-up reset, asynchronous, active low.
  input wire logic sclk, // Serial clock from the host.
  input wire logic cs_b, // Chip select from the host, active low.
  input wire logic [3:0] io_in, // Levels seen on data lines 0 to 3.
  output logic [3:0] io_out, // Levels driven on data lines 0 to 3.
  output logic [3:0] io_oe, // High while the device drives a data line.
  input wire logic quad_lines_enable, // Nonvolatile quad enable bit.
  input wire logic pause_pin_is_reset, // Line 3 is a reset input, not pause.
  input wire logic [1:0] register_protect_bits, // Status register protect setting.
  output logic status_write_block, // Status register writes are refused.
  output logic four_wire_instruction_mode, // Four-wire instruction mode active.
  output logic reset_busy, // Software or pin reset in progress.
  output logic [7:0] rx_byte, // Last byte received from the host.
  output logic rx_is_instruction, // That byte was the instruction byte.
  output logic rx_valid, // One-cycle pulse: new rx_byte.
  input wire logic [7:0] tx_byte, // Next read byte for the host.
  input wire logic tx_valid, // tx_byte is offered.
  output logic tx_ready // Front end can take tx_byte.
);

  // Link-side state, clocked by sclk; cs_seen_r is clocked by the falling chip select.
  logic link_rst_b;
  logic frm_rst_b;
  logic cs_seen_r;
  logic qe_s;
  logic hold_en_s;
  logic busy_s;
  logic tx_req_s;
  logic first_r;
  logic ignore_r;
  logic started_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [3:0] in_lanes_r;
  logic [3:0] out_lanes_r;
  logic [7:0] rx_hold_r;
  logic rx_first_r;
  logic rx_tgl_r;
  logic qpi_r;
  logic reset_armed_r;
  logic sreset_tgl_r;
  logic pause_r;
  logic drive_r;
  logic [3:0] tx_cnt_r;
  logic [7:0] tx_sh_r;
  logic tx_ack_r;

  // System-side state, clocked by clk.
  logic pin_reset_r;
  logic cs_high_s;
  logic wp_s;
  logic hold_s;
  logic rx_tgl_s;
  logic rx_tgl_seen_r;
  logic sreset_s;
  logic sreset_seen_r;
  logic qpi_s;
  logic tx_ack_s;
  logic tx_req_r;
  logic [7:0] tx_hold_r;
  logic [BUSY_CNT_W-1:0] busy_cnt_r;
  logic [7:0] rx_byte_r;
  logic rx_first_out_r;
  logic rx_valid_r;
  logic block_r;

  // The pin-driven reset is registered, so it cannot glitch the link reset.
  assign link_rst_b = rst_b & ~pin_reset_r;
  // Chip select high clears all frame state at once; sclk may not run then.
  assign frm_rst_b = link_rst_b & ~cs_b;

  // Level crossings into the link domain.
  bit_sync u_qe_link (.clk(sclk), .rst_b(link_rst_b), .d(quad_lines_enable), .q(qe_s));
  bit_sync u_hold_en (.clk(sclk), .rst_b(link_rst_b),
    .d(~quad_lines_enable & ~pause_pin_is_reset), .q(hold_en_s));
  bit_sync u_busy_link (.clk(sclk), .rst_b(link_rst_b), .d(reset_busy), .q(busy_s));
  bit_sync u_tx_req (.clk(sclk), .rst_b(link_rst_b), .d(tx_req_r), .q(tx_req_s));

  // A select is honoured only after a falling chip select since power-up; a select
  // already low when power comes up may carry a half-seen instruction.
  always_ff @(negedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      cs_seen_r <= 1'b0;
    end else begin
      cs_seen_r <= 1'b1;
    end
  end

  // Input decode: gather the lanes in use, top line into the top bit.
  logic [7:0] sh_nxt;
  logic [3:0] bit_cnt_nxt;
  logic byte_done;
  logic capture_en;
  logic [7:0] op;
  logic is_dual;
  logic is_quad;
  logic op_refused;
  logic [3:0] in_lanes;
  // The instruction byte takes its width from the mode, so the first edge is already right.
  assign in_lanes = first_r ? (qpi_r ? LANES_4 : LANES_1) : in_lanes_r;
  assign sh_nxt = (in_lanes == LANES_4) ? {sh_r[3:0], io_in[3:0]} :
    (in_lanes == LANES_2) ? {sh_r[5:0], io_in[1:0]} :
    {sh_r[6:0], io_in[LINE_IN]};
  assign bit_cnt_nxt = bit_cnt_r + in_lanes;
  assign byte_done = (bit_cnt_nxt == BITS_PER_BYTE);
  // Capture stops once the device drives, unless input is on line 0 alone.
  assign capture_en = ~pause_r & ~(drive_r & (in_lanes != LANES_1));
  assign op = sh_nxt;
  assign is_dual = (op == OP_DUAL_OUT_READ) | (op == OP_DUAL_IO_READ);
  assign is_quad = (op == OP_QUAD_OUT_READ) | (op == OP_QUAD_IO_READ) |
    (op == OP_QUAD_WORD_READ);
  assign op_refused = busy_s | ~cs_seen_r | (is_quad & ~qe_s & ~qpi_r);

  // Frame capture on rising edges; every frame starts with the instruction byte.
  always_ff @(posedge sclk or negedge frm_rst_b) begin
    if (!frm_rst_b) begin
      first_r <= 1'b1;
      ignore_r <= 1'b0;
      started_r <= 1'b0;
      bit_cnt_r <= BITS_NONE;
      sh_r <= 8'h00;
      in_lanes_r <= LANES_1;
      out_lanes_r <= LANES_1;
    end else if (capture_en) begin
      started_r <= 1'b1;
      sh_r <= sh_nxt;
      bit_cnt_r <= byte_done ? BITS_NONE : bit_cnt_nxt;
      if (first_r && !byte_done) begin
        in_lanes_r <= qpi_r ? LANES_4 : LANES_1;
      end
      if (first_r && byte_done) begin
        first_r <= 1'b0;
        ignore_r <= op_refused;
        in_lanes_r <= qpi_r ? LANES_4 : (op == OP_DUAL_IO_READ) ? LANES_2 :
          ((op == OP_QUAD_IO_READ) | (op == OP_QUAD_WORD_READ)) ? LANES_4 : LANES_1;
        out_lanes_r <= (qpi_r | is_quad) ? LANES_4 : is_dual ? LANES_2 : LANES_1;
      end
    end
  end

  // Handing each finished byte to the system side; the holding register
  // stays stable for at least two sclk periods, far above the crossing time.
  always_ff @(posedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      rx_hold_r <= 8'h00;
      rx_first_r <= 1'b0;
      rx_tgl_r <= 1'b0;
    end else if (cs_b == 1'b0 && capture_en && byte_done && !ignore_r &&
        !(first_r && op_refused)) begin
      rx_hold_r <= sh_nxt;
      rx_first_r <= first_r;
      rx_tgl_r <= ~rx_tgl_r;
    end
  end

  // Instruction-mode and software-reset sequencing, kept across frames.
  logic op_taken;
  assign op_taken = ~cs_b & capture_en & first_r & byte_done & ~op_refused;
  always_ff @(posedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      qpi_r <= 1'b0;
      reset_armed_r <= 1'b0;
      sreset_tgl_r <= 1'b0;
    end else if (op_taken) begin
      // Only the instruction right after 66h may be the reset itself.
      reset_armed_r <= (op == OP_RESET_ENABLE);
      if (op == OP_ENTER_FOUR_WIRE && qe_s) begin
        qpi_r <= 1'b1;
      end else if (op == OP_EXIT_FOUR_WIRE) begin
        qpi_r <= 1'b0;
      end else if (op == OP_RESET && reset_armed_r) begin
        qpi_r <= 1'b0;
        sreset_tgl_r <= ~sreset_tgl_r;
      end
    end
  end

  // Pause is sampled on falling edges, so it starts and ends there.
  // While the clock idles low the host must give one falling edge to apply it.
  always_ff @(negedge sclk or negedge frm_rst_b) begin
    if (!frm_rst_b) begin
      pause_r <= 1'b0;
    end else begin
      pause_r <= hold_en_s & ~io_in[LINE_PAUSE];
    end
  end

  // Read data shifter on falling edges; it needs a rising edge first so that
  // the leading falling edge of clock mode 3 does not shift anything.
  logic tx_pending;
  logic tx_last;
  assign tx_pending = (tx_req_s != tx_ack_r);
  assign tx_last = (tx_cnt_r <= out_lanes_r);
  always_ff @(negedge sclk or negedge frm_rst_b) begin
    if (!frm_rst_b) begin
      drive_r <= 1'b0;
      tx_cnt_r <= BITS_NONE;
      tx_sh_r <= 8'h00;
    end else if (started_r && !pause_r && !ignore_r && !first_r) begin
      if (tx_last && tx_pending) begin
        drive_r <= 1'b1;
        tx_sh_r <= tx_hold_r;
        tx_cnt_r <= BITS_PER_BYTE;
      end else if (tx_last) begin
        tx_cnt_r <= BITS_NONE;
      end else begin
        tx_sh_r <= tx_sh_r << out_lanes_r;
        tx_cnt_r <= tx_cnt_r - out_lanes_r;
      end
    end
  end

  // The acknowledge toggle survives chip select so the crossing stays balanced.
  always_ff @(negedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      tx_ack_r <= 1'b0;
    end else if (!cs_b && started_r && !pause_r && !ignore_r && !first_r &&
        tx_last && tx_pending) begin
      tx_ack_r <= ~tx_ack_r;
    end
  end

  // Output lines: top line carries the top bit of each group.
  logic drive_on;
  assign drive_on = drive_r & ~pause_r & ~cs_b & (tx_cnt_r != BITS_NONE);
  assign io_out = (out_lanes_r == LANES_4) ? tx_sh_r[7:4] :
    (out_lanes_r == LANES_2) ? {2'b00, tx_sh_r[7:6]} :
    {2'b00, tx_sh_r[7], 1'b0};
  assign io_oe = ~drive_on ? 4'h0 : (out_lanes_r == LANES_4) ? 4'hf :
    (out_lanes_r == LANES_2) ? 4'h3 : 4'h2;

  // Pin levels, the four-wire mode level and link-side toggles crossing into the system clock.
  bit_sync u_cs_sys (.clk(clk), .rst_b(rst_b), .d(cs_b), .q(cs_high_s));
  bit_sync u_wp_sys (.clk(clk), .rst_b(rst_b), .d(io_in[LINE_PROTECT]), .q(wp_s));
  bit_sync u_hold_sys (.clk(clk), .rst_b(rst_b), .d(io_in[LINE_PAUSE]), .q(hold_s));
  bit_sync u_rx_tgl (.clk(clk), .rst_b(rst_b), .d(rx_tgl_r), .q(rx_tgl_s));
  bit_sync u_sreset (.clk(clk), .rst_b(rst_b), .d(sreset_tgl_r), .q(sreset_s));
  bit_sync u_qpi_sys (.clk(clk), .rst_b(rst_b), .d(qpi_r), .q(qpi_s));
  bit_sync u_tx_ack (.clk(clk), .rst_b(rst_b), .d(tx_ack_r), .q(tx_ack_s));

  // Line 3 as reset: only with quad enable clear and the reset setting chosen.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_reset_r <= 1'b0;
    end else begin
      pin_reset_r <= ~quad_lines_enable & pause_pin_is_reset & ~hold_s;
    end
  end

  // Recovery timer after a software reset; the pin reset holds it too.
  logic sreset_event;
  assign sreset_event = (sreset_s != sreset_seen_r);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sreset_seen_r <= 1'b0;
      busy_cnt_r <= BUSY_IDLE;
    end else begin
      sreset_seen_r <= sreset_s;
      if (sreset_event || pin_reset_r) begin
        busy_cnt_r <= BUSY_LOAD;
      end else if (busy_cnt_r != BUSY_IDLE) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
    end
  end
  assign reset_busy = (busy_cnt_r != BUSY_IDLE);

  // Received bytes: stable holding register, read on the toggle edge.
  logic rx_event;
  assign rx_event = (rx_tgl_s != rx_tgl_seen_r);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_tgl_seen_r <= 1'b0;
      rx_byte_r <= 8'h00;
      rx_first_out_r <= 1'b0;
      rx_valid_r <= 1'b0;
    end else begin
      rx_tgl_seen_r <= rx_tgl_s;
      rx_valid_r <= rx_event;
      if (rx_event) begin
        rx_byte_r <= rx_hold_r;
        rx_first_out_r <= rx_first_r;
      end
    end
  end
  assign rx_byte = rx_byte_r;
  assign rx_is_instruction = rx_first_out_r;
  assign rx_valid = rx_valid_r;

  // Read byte offer: one byte in flight, held until the link acknowledges it.
  assign tx_ready = (tx_req_r == tx_ack_s);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_req_r <= 1'b0;
      tx_hold_r <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      tx_hold_r <= tx_byte;
      tx_req_r <= ~tx_req_r;
    end
  end

  // Status register write lock; the protect pin counts only while it is not data.
  logic pin_lock;
  assign pin_lock = ~quad_lines_enable & ~wp_s & (register_protect_bits == PROTECT_BY_PIN);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      block_r <= 1'b0;
    end else begin
      block_r <= pin_lock | register_protect_bits[PROTECT_LOCK_BIT];
    end
  end
  assign status_write_block = block_r;
  assign four_wire_instruction_mode = qpi_s;

endmodule : serial_flash_io_mode_control
`default_nettype wire
